// ### verilog/grayscale_port_pkg.sv
// Functional notes
// [R1] Each serial clock rising edge captures serial_data_in into shift register bit zero.
// [R2] Each serial clock rising edge moves the shift register one bit toward the top.
// [R3] serial_data_out changes only on the serial clock falling edge.
// [R4] serial_data_out comes from an extra stage after the top shift register bit.
// [R5] Latch strobe rising edge copies the whole shift register into a two-frame buffer if not full; the latch takes the oldest frame while latch_hold is low.
// [R6] After a latch load every sink output stays off until the next display period.
// [R7] Latch strobe leaves the PWM counter running; it is never cleared by the strobe.
// [R8] Each channel has a 12-bit grayscale field selecting one of 4096 duty steps.
// [R9] Blank high forces outputs off and holds the counter at zero; low lets PWM run.
// [R10] Host shifts 288 bits, top channel and top bit first, then pulses the strobe.
package grayscale_port_pkg;

  localparam int CHANNELS       = 24;
  localparam int GS_BITS        = 12;
  localparam int FRAME_BITS     = CHANNELS * GS_BITS;
  localparam int PWM_STEPS      = 4096;
  localparam int FIFO_DEPTH     = 2;
  localparam int PTR_BITS       = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CNT_BITS       = $clog2(FIFO_DEPTH + 1);

  // Host keeps the serial clock still this long after a strobe edge
  localparam int CORE_CLK_MHZ     = 200;
  localparam int LATCH_SETUP_NS   = 100;
  localparam int LATCH_SETUP_CYC  = (LATCH_SETUP_NS * CORE_CLK_MHZ) / 1000;

  localparam logic [GS_BITS-1:0]  PWM_LAST     = GS_BITS'(PWM_STEPS - 1);
  localparam logic [CNT_BITS-1:0] FIFO_FULL    = CNT_BITS'(FIFO_DEPTH);

  typedef struct packed {
    logic                  rst_meta;
    logic                  rst_sync;
    logic [FRAME_BITS-1:0] shift;
  } link_state_type;

  typedef struct packed {
    logic sdo;
  } out_state_type;

  typedef struct packed {
    logic                                  blank_meta;
    logic                                  blank_sync;
    logic                                  strobe_meta;
    logic                                  strobe_sync;
    logic                                  strobe_prev;
    logic [FIFO_DEPTH-1:0][FRAME_BITS-1:0] mem;
    logic [PTR_BITS-1:0]                   wr_ptr;
    logic [PTR_BITS-1:0]                   rd_ptr;
    logic [CNT_BITS-1:0]                   count;
    logic [FRAME_BITS-1:0]                 gs_latch;
    logic [GS_BITS-1:0]                    pwm_cnt;
    logic                                  force_off;
    logic [CHANNELS-1:0]                   sink;
    logic                                  frame_room;
  } core_state_type;

  localparam link_state_type LINK_STATE_RST = '0;
  localparam out_state_type  OUT_STATE_RST  = '0;
  localparam core_state_type CORE_STATE_RST = '0;

endpackage : grayscale_port_pkg

// ### verilog/grayscale_shift_latch_port.sv
`timescale 1ns/1ps
module grayscale_shift_latch_port
  import grayscale_port_pkg::*;
(
  // Core clock and reset
  input  wire logic                core_clk,
  input  wire logic                srst,
  // Serial link, clocked by the host
  input  wire logic                serial_clk,
  input  wire logic                serial_data_in,
  output logic                     serial_data_out,
  // Asynchronous control pins
  input  wire logic                latch_strobe,
  input  wire logic                blank_in,
  // Frame buffer flow control
  input  wire logic                latch_hold,
  output logic                     frame_room,
  // Sink channels, bit 0 is sink_channel_first, top bit is sink_channel_last
  output logic [CHANNELS-1:0]      sink_channel_on
);

  function automatic logic [GS_BITS-1:0] gs_field(input logic [FRAME_BITS-1:0] frame,
                                                  input int idx);
    gs_field = frame[idx*GS_BITS +: GS_BITS]; // R8 R10
  endfunction : gs_field

  link_state_type link_r;
  link_state_type link_nxt;
  out_state_type  out_r;
  out_state_type  out_nxt;
  core_state_type core_r;
  core_state_type core_nxt;
  logic           push;
  logic           pop;
  logic           strobe_rise;

  // Link domain: reset is brought over by two flops since the host clock may stop
  always_comb begin
    link_nxt          = link_r;
    link_nxt.rst_meta = srst;
    link_nxt.rst_sync = link_r.rst_meta;
    link_nxt.shift    = {link_r.shift[FRAME_BITS-2:0], serial_data_in}; // R1 R2
    if (link_r.rst_sync) begin
      link_nxt.shift = LINK_STATE_RST.shift;
    end
  end

  always_ff @(posedge serial_clk) begin
    link_r <= link_nxt;
  end

  // Extra stage on the falling edge gives the next device half a clock of margin
  always_comb begin
    out_nxt     = out_r;
    out_nxt.sdo = link_r.shift[FRAME_BITS-1]; // R4
    if (link_r.rst_sync) begin
      out_nxt = OUT_STATE_RST;
    end
  end

  always_ff @(negedge serial_clk) begin
    out_r <= out_nxt; // R3
  end

  assign serial_data_out = out_r.sdo;

  // Core domain
  assign strobe_rise = core_r.strobe_sync & ~core_r.strobe_prev;
  assign push        = strobe_rise & (core_r.count != FIFO_FULL);
  assign pop         = (core_r.count != '0) & ~latch_hold;

  always_comb begin
    core_nxt             = core_r;
    core_nxt.blank_meta  = blank_in;
    core_nxt.blank_sync  = core_r.blank_meta;
    core_nxt.strobe_meta = latch_strobe;
    core_nxt.strobe_sync = core_r.strobe_meta;
    core_nxt.strobe_prev = core_r.strobe_sync;
    // Shift register is quiet here: the host may not clock it right after the strobe
    if (push) begin
      core_nxt.mem[core_r.wr_ptr] = link_r.shift; // R5
      core_nxt.wr_ptr             = core_r.wr_ptr + PTR_BITS'(1);
    end
    // Counter ignores the strobe entirely
    if (core_r.blank_sync) begin
      core_nxt.pwm_cnt   = '0; // R9
      core_nxt.force_off = 1'b0;
    end else begin
      core_nxt.pwm_cnt = core_r.pwm_cnt + GS_BITS'(1); // R7
      if (core_r.pwm_cnt == PWM_LAST) begin
        core_nxt.force_off = 1'b0; // R6
      end
    end
    // Load after the clear so that a load on the wrap cycle still blanks a period
    if (pop) begin
      core_nxt.gs_latch  = core_r.mem[core_r.rd_ptr]; // R5
      core_nxt.rd_ptr    = core_r.rd_ptr + PTR_BITS'(1);
      core_nxt.force_off = 1'b1; // R6
    end
    core_nxt.count      = CNT_BITS'(core_r.count + CNT_BITS'(push) - CNT_BITS'(pop));
    core_nxt.frame_room = (core_nxt.count != FIFO_FULL);
    for (int i = 0; i < CHANNELS; i++) begin
      core_nxt.sink[i] = ~core_r.blank_sync & ~core_nxt.force_off &
                         (core_nxt.pwm_cnt < gs_field(core_nxt.gs_latch, i)); // R8 R9
    end
    if (srst) begin
      core_nxt = CORE_STATE_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    core_r <= core_nxt;
  end

  assign frame_room      = core_r.frame_room;
  assign sink_channel_on = core_r.sink;

  // Checks, link domain
  property p_capture_lsb;
    @(posedge serial_clk) disable iff (link_r.rst_sync)
      !$past(link_r.rst_sync) |-> link_r.shift[0] == $past(serial_data_in);
  endproperty
  a_capture_lsb: assert property (p_capture_lsb) else $error("serial bit not captured"); // R1

  property p_shift_up;
    @(posedge serial_clk) disable iff (link_r.rst_sync)
      !$past(link_r.rst_sync) |->
        link_r.shift[FRAME_BITS-1:1] == $past(link_r.shift[FRAME_BITS-2:0]);
  endproperty
  a_shift_up: assert property (p_shift_up) else $error("shift register did not move"); // R2

  property p_out_falling;
    @(negedge serial_clk) disable iff (link_r.rst_sync)
      !$past(link_r.rst_sync) |-> serial_data_out == $past(link_r.shift[FRAME_BITS-1]);
  endproperty
  a_out_falling: assert property (p_out_falling) else $error("output not on falling edge"); // R3

  property p_out_stage;
    @(posedge serial_clk) disable iff (link_r.rst_sync)
      $past(!link_r.rst_sync, 2) |-> serial_data_out == link_r.shift[FRAME_BITS-1];
  endproperty
  a_out_stage: assert property (p_out_stage) else $error("output stage lost the top bit"); // R4

  property p_link_clear;
    @(posedge serial_clk)
      link_r.rst_sync |=> link_r.shift == '0;
  endproperty
  a_link_clear: assert property (p_link_clear) else $error("shift not cleared"); // R2

  property p_out_reset;
    @(negedge serial_clk)
      link_r.rst_sync |=> serial_data_out == 1'b0;
  endproperty
  a_out_reset: assert property (p_out_reset) else $error("serial output not cleared"); // R4

  // Checks, core domain
  sequence s_strobe_empty;
    strobe_rise && core_r.count == '0;
  endsequence

  sequence s_drain_free;
    !latch_hold;
  endsequence

  property p_latch_copy;
    @(posedge core_clk) disable iff (srst)
      s_strobe_empty ##1 s_drain_free |=> core_r.gs_latch == $past(link_r.shift, 2);
  endproperty
  a_latch_copy: assert property (p_latch_copy) else $error("latch did not take frame"); // R5

  property p_load_blanks;
    @(posedge core_clk) disable iff (srst)
      pop |=> (sink_channel_on == '0) && core_r.force_off;
  endproperty
  a_load_blanks: assert property (p_load_blanks) else $error("outputs on after load"); // R6

  property p_off_until_period;
    @(posedge core_clk) disable iff (srst)
      core_r.force_off && !pop && core_r.pwm_cnt != PWM_LAST && !core_r.blank_sync |=>
        core_r.force_off && sink_channel_on == '0;
  endproperty
  a_off_until_period: assert property (p_off_until_period) else $error("hold-off too short"); // R6

  property p_strobe_keeps_count;
    @(posedge core_clk) disable iff (srst)
      strobe_rise && !core_r.blank_sync |=> core_r.pwm_cnt == $past(core_r.pwm_cnt) + 12'h001;
  endproperty
  a_strobe_keeps_count: assert property (p_strobe_keeps_count) else $error("counter moved"); // R7

  property p_period_wrap;
    @(posedge core_clk) disable iff (srst)
      core_r.pwm_cnt == PWM_LAST && !core_r.blank_sync |=> core_r.pwm_cnt == '0;
  endproperty
  a_period_wrap: assert property (p_period_wrap) else $error("period is not 4096 steps"); // R8

  generate
    for (genvar g = 0; g < CHANNELS; g += CHANNELS - 1) begin : g_dark
      property p_zero_dark;
        @(posedge core_clk) disable iff (srst)
          gs_field(core_r.gs_latch, g) == '0 |-> !sink_channel_on[g];
      endproperty
      a_zero_dark: assert property (p_zero_dark) else $error("zero value channel lit"); // R8
    end
  endgenerate

  property p_blank_holds;
    @(posedge core_clk) disable iff (srst)
      core_r.blank_sync |=> core_r.pwm_cnt == '0 && sink_channel_on == '0;
  endproperty
  a_blank_holds: assert property (p_blank_holds) else $error("blank not honoured"); // R9

  // Checks, synchronisers and frame buffer
  property p_blank_chain;
    @(posedge core_clk) disable iff (srst)
      core_r.blank_sync == $past(core_r.blank_meta);
  endproperty
  a_blank_chain: assert property (p_blank_chain) else $error("blank sync broken"); // R9

  property p_strobe_chain;
    @(posedge core_clk) disable iff (srst)
      core_r.strobe_sync == $past(core_r.strobe_meta) &&
        core_r.strobe_prev == $past(core_r.strobe_sync);
  endproperty
  a_strobe_chain: assert property (p_strobe_chain) else $error("strobe sync broken"); // R5

  property p_strobe_queues;
    @(posedge core_clk) disable iff (srst)
      s_strobe_empty |=> core_r.count == CNT_BITS'(1);
  endproperty
  a_strobe_queues: assert property (p_strobe_queues) else $error("frame not queued"); // R5

  property p_full_drops;
    @(posedge core_clk) disable iff (srst)
      strobe_rise && core_r.count == FIFO_FULL && latch_hold |=>
        core_r.count == FIFO_FULL && $stable(core_r.wr_ptr);
  endproperty
  a_full_drops: assert property (p_full_drops) else $error("frame taken while full"); // R5

  property p_count_bound;
    @(posedge core_clk) disable iff (srst)
      core_r.count <= FIFO_FULL;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("buffer count overflow"); // R5

  property p_room_flag;
    @(posedge core_clk) disable iff (srst)
      !$past(srst) |-> frame_room == (core_r.count != FIFO_FULL);
  endproperty
  a_room_flag: assert property (p_room_flag) else $error("frame_room wrong"); // R5

  property p_pop_oldest;
    @(posedge core_clk) disable iff (srst)
      pop |=> core_r.gs_latch == $past(core_r.mem[core_r.rd_ptr]);
  endproperty
  a_pop_oldest: assert property (p_pop_oldest) else $error("latch took wrong frame"); // R5

  property p_hold_keeps;
    @(posedge core_clk) disable iff (srst)
      latch_hold |=> $stable(core_r.gs_latch);
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("latch moved while held"); // R5

  // Checks, display period
  sequence s_load_on_wrap;
    pop && core_r.pwm_cnt == PWM_LAST && !core_r.blank_sync;
  endsequence

  property p_load_on_wrap;
    @(posedge core_clk) disable iff (srst)
      s_load_on_wrap |=> core_r.force_off && core_r.pwm_cnt == '0;
  endproperty
  a_load_on_wrap: assert property (p_load_on_wrap) else $error("wrap load not blanked"); // R6

  property p_wrap_releases;
    @(posedge core_clk) disable iff (srst)
      core_r.force_off && !pop && core_r.pwm_cnt == PWM_LAST && !core_r.blank_sync |=>
        !core_r.force_off;
  endproperty
  a_wrap_releases: assert property (p_wrap_releases) else $error("hold-off not released"); // R6

  property p_blank_clears_hold;
    @(posedge core_clk) disable iff (srst)
      core_r.blank_sync && !pop |=> !core_r.force_off;
  endproperty
  a_blank_clears_hold: assert property (p_blank_clears_hold) else $error("hold-off kept"); // R9

  property p_count_runs;
    @(posedge core_clk) disable iff (srst)
      !core_r.blank_sync |=> core_r.pwm_cnt == $past(core_r.pwm_cnt) + 12'h001;
  endproperty
  a_count_runs: assert property (p_count_runs) else $error("counter stalled"); // R7

  generate
    for (genvar g = 0; g < CHANNELS; g++) begin : g_duty
      property p_sink_duty;
        @(posedge core_clk) disable iff (srst)
          !core_r.force_off && !$past(core_r.blank_sync) |->
            sink_channel_on[g] == (core_r.pwm_cnt < gs_field(core_r.gs_latch, g));
      endproperty
      a_sink_duty: assert property (p_sink_duty) else $error("sink duty wrong"); // R8
      property p_sink_dark;
        @(posedge core_clk) disable iff (srst)
          core_r.force_off |-> !sink_channel_on[g];
      endproperty
      a_sink_dark: assert property (p_sink_dark) else $error("sink lit in hold-off"); // R6
    end
  endgenerate

endmodule : grayscale_shift_latch_port

// ### verif/serial_host.sv
`timescale 1ns/1ps
module serial_host
  import grayscale_port_pkg::*;
(
  // Core clock, paces the strobe
  input  wire logic core_clk,
  // Serial link
  output logic      serial_clk,
  output logic      serial_data_in,
  input  wire logic serial_data_out,
  // Latch pin
  output logic      latch_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    latch_strobe = 1'b0;
  end
  // Link clock only runs inside these tasks, 6 ns period
  task automatic clocks(input int n);
    repeat (n) begin
      #3 serial_clk = 1'b1;
      #3 serial_clk = 1'b0;
    end
  endtask : clocks
  task automatic send(input logic [FRAME_BITS-1:0] f, output logic [FRAME_BITS-1:0] seen);
    for (int k = FRAME_BITS - 1; k >= 0; k--) begin
      serial_data_in = f[k];
      #3 serial_clk = 1'b1;
      #1.5 seen[k] = serial_data_out;
      #1.5 serial_clk = 1'b0;
    end
    // Released line shows no stale bit
    serial_data_in = ~serial_data_in;
    #3;
  endtask : send
  task automatic strobe();
    @(negedge core_clk) latch_strobe = 1'b1;
    repeat (3) @(negedge core_clk);
    latch_strobe = 1'b0;
  endtask : strobe
endmodule : serial_host

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
  import grayscale_port_pkg::*;
  logic                  core_clk, srst, latch_hold, blank_in, frame_room;
  logic                  serial_clk, serial_data_in, serial_data_out, latch_strobe;
  logic [CHANNELS-1:0]   sink_channel_on;
  logic [FRAME_BITS-1:0] frame, seen;
  int                    n_errors, checked, cyc, t0;

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  grayscale_shift_latch_port dut_u (.core_clk(core_clk), .srst(srst),
    .serial_clk(serial_clk), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .latch_strobe(latch_strobe), .blank_in(blank_in),
    .latch_hold(latch_hold), .frame_room(frame_room), .sink_channel_on(sink_channel_on));
  serial_host host_u (.core_clk(core_clk), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .latch_strobe(latch_strobe));

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic check_v(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_v
  task automatic check_f(input string what, input logic [FRAME_BITS-1:0] exp, got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_f
  // Bounded wait for the first lit sink
  task automatic wait_lit(input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge core_clk);
      if (sink_channel_on !== '0) break;
    end
    if (i == lim) begin
      n_errors++;
      close_out();
    end
  endtask : wait_lit

  task automatic shift_chain();
    host_u.send(frame, seen);
    host_u.send(frame, seen);
    check_f("serial_data_out", frame, seen);
  endtask : shift_chain
  task automatic latch_first();
    host_u.strobe();
    wait_lit(9000);
    t0 = cyc;
    check_v("sinks at count 0", 32'(24'hFFFFFE), 32'(sink_channel_on));
    @(negedge core_clk);
    check_v("sinks at count 1", 32'(24'hFFFFFC), 32'(sink_channel_on));
  endtask : latch_first
  // Load lands while the old frame is still lit
  task automatic latch_midperiod();
    host_u.strobe();
    repeat (8) @(negedge core_clk);
    check_v("sinks after load", 32'h0, 32'(sink_channel_on));
    wait_lit(9000);
    check_v("relight offset", 32'h1000, 32'(cyc - t0));
  endtask : latch_midperiod
  task automatic buffer_fill();
    latch_hold = 1'b1;
    host_u.strobe();
    repeat (4) @(negedge core_clk);
    host_u.strobe();
    repeat (4) @(negedge core_clk);
    check_v("frame_room full", 32'h0, 32'(frame_room));
    host_u.strobe();
    repeat (4) @(negedge core_clk);
    check_v("frame_room still full", 32'h0, 32'(frame_room));
    latch_hold = 1'b0;
    repeat (4) @(negedge core_clk);
    check_v("frame_room drained", 32'h1, 32'(frame_room));
  endtask : buffer_fill
  task automatic blank_span();
    wait_lit(9000);
    @(negedge core_clk) blank_in = 1'b1;
    repeat (6) @(negedge core_clk);
    check_v("sinks blanked", 32'h0, 32'(sink_channel_on));
    repeat (4200) @(negedge core_clk);
    check_v("sinks blanked wrap", 32'h0, 32'(sink_channel_on));
    blank_in = 1'b0;
    wait_lit(8);
    // Count step zero still sees the blank flop, so step one is the first lit
    check_v("sinks after blank", 32'(24'hFFFFFC), 32'(sink_channel_on));
  endtask : blank_span

  initial begin
    srst = 1'b1;
    latch_hold = 1'b0;
    blank_in = 1'b0;
    cyc = 0;
    for (int i = 0; i < CHANNELS; i++) frame[i*GS_BITS +: GS_BITS] = GS_BITS'(i);
    host_u.clocks(4);
    repeat (16) @(negedge core_clk);
    srst = 1'b0;
    host_u.clocks(4);
    shift_chain();
    repeat (25) @(negedge core_clk);
    latch_first();
    latch_midperiod();
    buffer_fill();
    blank_span();
    close_out();
  end
endmodule : tb
